// ==== rtl/sbc_spi_register_bank.sv ====
// Serial register bank: control and status registers behind a 16-bit SPI slave.
// Assumes clk far faster than the serial clock; all link pins are asynchronous.
// Function
// - One 16-bit frame: address, mode, data
// - Data bits D0..D7 at frame bits 8..15
// - Bit 7 low only reads
// - Bit 7 high writes one byte
// - Reserved bits read zero, host writes zero
// - Reset loads power-on values everywhere
// - Restart loads restart values, x bits kept
// - Lockable bits ignore writes when locked
// - Level-0 lock survives soft reset, pump/GPIO
// - Level-1 lock holds until power-on reset
// - Soft reset restores control bits except locked ones
// - Only rwh bits change by hardware
// - Read-only and reserved bits ignore writes
// - Each frame addresses exactly one register
// - Address 01h is mode and supply control
// - Address 1Ch is PWM frequency control
// - Addresses 1Fh/1Eh are status control high/low
// - Status byte cleared by write access
// - Writes apply at chip select rise
// - Frames ignored during restart mode
`timescale 1ns/1ps
module sbc_spi_register_bank
  import sbc_spi_pkg::*;
#(
  parameter logic [7:0] FAMILY_ID = 8'h5A  // Arbitrary neutral identity value
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // Serial link pins
  input  wire logic                      sclk,
  input  wire logic                      csn,
  input  wire logic                      mosi,
  output logic                           miso,
  output logic                           misoOeN,
  // Device state inputs
  input  wire logic                      restartMode,
  input  wire logic                      restartEntry,
  input  wire logic                      hwWrite,
  input  wire logic [4:0]                hwAddr,
  input  wire logic [7:0]                hwData,
  input  wire sbc_spi_pkg::stat_events_t statusSet,
  input  wire logic [7:0]                wakeLevel,
  // Register contents and frame events
  output sbc_spi_pkg::ctrl_image_t       ctrlImage,
  output sbc_spi_pkg::spi_frame_t        lastFrame,
  output logic                           frameDone,
  output logic                           softResetPulse
);
  import sbc_spi_pkg::*;

  // Writable bit mask of each control offset; zero when unmapped
  function automatic logic [7:0] ctrlMask(input logic [6:0] a);
    case (a)
      ADDR_MODE_SUPPLY:   ctrlMask = MASK_MODE_SUPPLY;
      ADDR_HARDWARE_CONTROL_0:     ctrlMask = MASK_HARDWARE_CONTROL_0;
      ADDR_WATCHDOG:      ctrlMask = MASK_WATCHDOG;
      ADDR_BUS_CTRL_0:    ctrlMask = MASK_BUS_CTRL_0;
      ADDR_INT_WAKE:      ctrlMask = MASK_INT_WAKE;
      ADDR_EXT_WAKE:      ctrlMask = MASK_EXT_WAKE;
      ADDR_WAKE_PULL:     ctrlMask = MASK_WAKE_PULL;
      ADDR_BUS_CTRL_3:    ctrlMask = MASK_BUS_CTRL_3;
      ADDR_CYCLIC_TIMER:  ctrlMask = MASK_TIMER;
      ADDR_HARDWARE_CONTROL_1:     ctrlMask = MASK_HARDWARE_CONTROL_1;
      ADDR_HARDWARE_CONTROL_2:     ctrlMask = MASK_HARDWARE_CONTROL_2;
      ADDR_GPIO_CONFIG:   ctrlMask = MASK_GPIO;
      ADDR_PWM_DUTY:      ctrlMask = MASK_FULL;
      ADDR_PWM_FREQ:      ctrlMask = MASK_PWM_FREQ;
      ADDR_HARDWARE_CONTROL_3:     ctrlMask = MASK_HARDWARE_CONTROL_3;
      ADDR_SYS_STAT_LOW:  ctrlMask = MASK_FULL;
      ADDR_SYS_STAT_HIGH: ctrlMask = MASK_FULL;
      default:            ctrlMask = MASK_NONE;
    endcase
  endfunction : ctrlMask

  // Bits frozen by the locks; on soft reset the set lock bits freeze too
  function automatic logic [7:0] lockMask(input logic [6:0] a, input logic l0,
                                          input logic l1, input logic sr);
    case (a)
      ADDR_HARDWARE_CONTROL_0:   lockMask = ((l0 | l1) ? BIT_PUMP_EN : MASK_NONE)
                                 | (l1 ? BIT_SOFT_RST_CFG : MASK_NONE);
      ADDR_GPIO_CONFIG: lockMask = (l0 | l1) ? MASK_GPIO : MASK_NONE;
      ADDR_HARDWARE_CONTROL_1:   lockMask = (sr & l0) ? BIT_LOCK0 : MASK_NONE;
      ADDR_HARDWARE_CONTROL_2:   lockMask = l1 ? BIT_LOCK1 : MASK_NONE;
      default:          lockMask = MASK_NONE;
    endcase
  endfunction : lockMask

  // Bits kept unchanged on restart entry
  function automatic logic [7:0] restartKeep(input logic [6:0] a);
    case (a)
      ADDR_MODE_SUPPLY: restartKeep = KEEP_MODE_SUPPLY;
      ADDR_HARDWARE_CONTROL_0:   restartKeep = KEEP_HARDWARE_CONTROL_0;
      default:          restartKeep = MASK_FULL;
    endcase
  endfunction : restartKeep

  // Bits the device itself may update
  function automatic logic [7:0] rwhMask(input logic [6:0] a);
    case (a)
      ADDR_MODE_SUPPLY: rwhMask = RWH_MODE_SUPPLY;
      ADDR_HARDWARE_CONTROL_0:   rwhMask = RWH_HARDWARE_CONTROL_0;
      default:          rwhMask = MASK_NONE;
    endcase
  endfunction : rwhMask

  // Synchroniser stages for the link pins
  logic       sclkMeta, sclkSync, sclkLast;   // Serial clock
  logic       csnMeta,  csnSync,  csnLast;    // Chip select
  logic       mosiMeta, mosiSync;             // Serial data in

  // Frame state
  logic [CNT_W-1:0] bitCount;                 // Falling edges seen in the frame
  logic [15:0]      rxShift;                  // Received bits, first bit lands in bit 0
  logic [15:0]      next_rxShift;             // Shift register after this sample
  logic [7:0]       statusInfo;               // Summary byte sent first
  logic [7:0]       dataOut;                  // Addressed register, sent second
  logic [7:0]       readValue;                // Read mux result
  logic             frameIgnored;             // Restart seen during the frame
  spi_frame_t       rxFrame;                  // Received frame view
  logic [6:0]       lookAddr;                 // Address being read

  // Register storage
  logic [7:0] ctrlReg [CTRL_DEPTH];           // Control space
  logic [7:0] statReg [STAT_COUNT];           // Clearable status bytes
  logic       lock0;                          // Level-0 lock bit
  logic       lock1;                          // Level-1 lock bit

  // Edge and strobe terms
  logic sclkRise, sclkFall, csnFall, csnRise, commit, doWrite, softReset;

  // Two flip-flops on each pin, a third stage only for edge finding
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      csnMeta  <= 1'b1;
      csnSync  <= 1'b1;
      csnLast  <= 1'b1;
      mosiMeta <= 1'b0;
      mosiSync <= 1'b0;
    end else begin
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      csnMeta  <= csn;
      csnSync  <= csnMeta;
      csnLast  <= csnSync;
      mosiMeta <= mosi;
      mosiSync <= mosiMeta;
    end
  end

  // Edges of the synchronised link signals
  assign sclkRise = !csnSync && sclkSync && !sclkLast;
  assign sclkFall = !csnSync && !sclkSync && sclkLast;
  assign csnFall  = !csnSync && csnLast;
  assign csnRise  = csnSync && !csnLast;

  // Frame decode; a complete frame commits only at chip select rise
  assign next_rxShift = {mosiSync, rxShift[15:1]};
  assign rxFrame      = spi_frame_t'(rxShift);
  assign commit       = csnRise && (bitCount == FRAME_BITS) && !frameIgnored
                        && !restartMode;
  assign doWrite      = commit && rxFrame.write;
  assign softReset    = doWrite && (rxFrame.addr == ADDR_MODE_SUPPLY)
                        && (rxFrame.data[MODE_HI:MODE_LO] == MODE_SOFT_RESET);
  assign lock0        = |(ctrlReg[ADDR_HARDWARE_CONTROL_1[4:0]] & BIT_LOCK0);
  assign lock1        = |(ctrlReg[ADDR_HARDWARE_CONTROL_2[4:0]] & BIT_LOCK1);

  // Bit counter and receive shifter, LSB first, sampled on falling edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bitCount <= '0;
      rxShift  <= '0;
    end else if (csnFall) begin
      bitCount <= '0;
      rxShift  <= '0;
    end else if (sclkFall) begin
      rxShift  <= next_rxShift;
      // Saturate so an over-long frame can never look complete
      if (bitCount != OVERRUN) begin
        bitCount <= bitCount + 5'h01;
      end
    end
  end

  // Frames touched by restart mode are dropped whole
  always_ff @(posedge clk) begin
    if (!nrst) begin
      frameIgnored <= 1'b0;
    end else if (csnFall) begin
      frameIgnored <= restartMode;
    end else if (restartMode) begin
      // Restart arriving mid-frame spoils the frame too
      frameIgnored <= 1'b1;
    end
  end

  // Summary byte: one bit per status register group
  always_comb begin
    statusInfo    = '0;
    statusInfo[0] = |statReg[1];
    statusInfo[1] = |statReg[2];
    statusInfo[2] = |statReg[3];
    statusInfo[3] = |statReg[4];
    statusInfo[4] = |statReg[5] | |statReg[6];
    statusInfo[5] = |statReg[0];
    statusInfo[6] = |statReg[7];
    statusInfo[7] = |statReg[8];
  end

  // Read mux on the address as it completes; shows the value before any write
  always_comb begin
    lookAddr  = next_rxShift[14:8];
    readValue = '0;
    if (lookAddr < 7'(CTRL_DEPTH)) begin
      readValue = ctrlReg[lookAddr[4:0]] & ctrlMask(lookAddr);
    end else if (lookAddr == ADDR_WAKE_LEVEL) begin
      readValue = wakeLevel & WAKE_LEVEL_MASK;
    end else if (lookAddr == ADDR_FAMILY_ID) begin
      readValue = FAMILY_ID;
    end else begin
      for (int k = 0; k < STAT_COUNT; k++) begin
        // Address table match picks the status byte
        if (lookAddr == STAT_ADDR[k]) begin
          readValue = statReg[k];
        end
      end
    end
  end

  // Latch the data byte once the address byte is in
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dataOut <= '0;
    end else if (sclkFall && (bitCount == ADDR_BITS - 5'h01)) begin
      // Value before any write of this frame
      dataOut <= readValue;
    end
  end

  // Serial output: bit 0 at select, next bit on each rising edge after a sample
  always_ff @(posedge clk) begin
    if (!nrst) begin
      miso <= 1'b0;
    end else if (csnFall) begin
      miso <= statusInfo[0];
    end else if (sclkRise && (bitCount != '0) && (bitCount < FRAME_BITS)) begin
      // Summary byte first, then the addressed register
      if (bitCount < ADDR_BITS) begin
        miso <= statusInfo[bitCount[2:0]];
      end else begin
        miso <= dataOut[bitCount[2:0]];
      end
    end
  end

  // Output driven only while selected and outside restart
  assign misoOeN = csnSync || restartMode;

  // Control registers: reset, restart, host write or soft reset, hardware update
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < CTRL_DEPTH; i++) begin
        ctrlReg[i] <= POR_VALUE;
      end
    end else begin
      // Restart entry outranks soft reset and host writes
      if (restartEntry) begin
        for (int i = 0; i < CTRL_DEPTH; i++) begin
          ctrlReg[i] <= ((ctrlReg[i] & restartKeep(7'(i)))
                        | (RESTART_VALUE & ~restartKeep(7'(i))))
                        & ctrlMask(7'(i));
        end
      end else if (softReset) begin
        // Locked bits and set lock bits ride through
        for (int i = 0; i < CTRL_DEPTH; i++) begin
          ctrlReg[i] <= ((ctrlReg[i] & lockMask(7'(i), lock0, lock1, 1'b1))
                        | (POR_VALUE & ~lockMask(7'(i), lock0, lock1, 1'b1)))
                        & ctrlMask(7'(i));
        end
      end else if (doWrite && (rxFrame.addr < 7'(CTRL_DEPTH))) begin
        // Only writable, unlocked bits take the host data
        ctrlReg[rxFrame.addr[4:0]] <=
          (ctrlReg[rxFrame.addr[4:0]] & lockMask(rxFrame.addr, lock0, lock1, 1'b0))
          | (rxFrame.data & ctrlMask(rxFrame.addr)
             & ~lockMask(rxFrame.addr, lock0, lock1, 1'b0));
      end
      // A device update rewrites its whole register and drops a host write or soft reset of that register in the same cycle
      if (hwWrite && !restartEntry) begin
        ctrlReg[hwAddr] <= (ctrlReg[hwAddr] & ~rwhMask({2'b00, hwAddr}))
                           | (hwData & rwhMask({2'b00, hwAddr}));
      end
    end
  end

  // Control space seen by the device functions
  always_comb begin
    for (int i = 0; i < CTRL_DEPTH; i++) begin
      ctrlImage[i] = ctrlReg[i];
    end
  end

  // Status registers: hardware sets, write access clears, set wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int k = 0; k < STAT_COUNT; k++) begin
        statReg[k] <= '0;
      end
    end else begin
      for (int k = 0; k < STAT_COUNT; k++) begin
        if (doWrite && (rxFrame.addr == STAT_ADDR[k])) begin
          // Clear the byte but keep events arriving this cycle
          statReg[k] <= statusSet[k] & STAT_MASK[k];
        end else begin
          statReg[k] <= (statReg[k] | statusSet[k]) & STAT_MASK[k];
        end
      end
    end
  end

  // Frame report and soft reset strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lastFrame      <= '0;
      frameDone      <= 1'b0;
      softResetPulse <= 1'b0;
    end else begin
      frameDone      <= commit;
      softResetPulse <= softReset;
      // Keep the last committed frame for the device functions
      if (commit) begin
        lastFrame <= rxFrame;
      end
    end
  end

endmodule : sbc_spi_register_bank

// ==== rtl/sbc_spi_pkg.sv ====
// Constants and types for the serial register bank of a system basis chip.
// Assumes a single 40 MHz system clock; the serial link is sampled, not clocked on.
package sbc_spi_pkg;

  // Frame geometry
  localparam int          ADDR_W      = 7;        // Register address width
  localparam int          DATA_W      = 8;        // Data byte width
  localparam int          CNT_W       = 5;        // Bit counter width
  localparam logic [4:0]  FRAME_BITS  = 5'h10;    // Bits in one frame
  localparam logic [4:0]  ADDR_BITS   = 5'h08;    // Bits before the data byte
  localparam logic [4:0]  OVERRUN     = 5'h11;    // Saturation value of the counter
  localparam int          CTRL_DEPTH  = 32;       // Control address space
  localparam int          STAT_COUNT  = 9;        // Clearable status registers

  // Control register offsets
  localparam logic [6:0] ADDR_MODE_SUPPLY   = 7'h01;
  localparam logic [6:0] ADDR_HARDWARE_CONTROL_0     = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG      = 7'h03;
  localparam logic [6:0] ADDR_BUS_CTRL_0    = 7'h04;
  localparam logic [6:0] ADDR_INT_WAKE      = 7'h06;
  localparam logic [6:0] ADDR_EXT_WAKE      = 7'h07;
  localparam logic [6:0] ADDR_WAKE_PULL     = 7'h08;
  localparam logic [6:0] ADDR_BUS_CTRL_3    = 7'h0B;
  localparam logic [6:0] ADDR_CYCLIC_TIMER  = 7'h0C;
  localparam logic [6:0] ADDR_HARDWARE_CONTROL_1     = 7'h0E;
  localparam logic [6:0] ADDR_HARDWARE_CONTROL_2     = 7'h0F;
  localparam logic [6:0] ADDR_GPIO_CONFIG   = 7'h17;
  localparam logic [6:0] ADDR_PWM_DUTY      = 7'h18;
  localparam logic [6:0] ADDR_PWM_FREQ      = 7'h1C;
  localparam logic [6:0] ADDR_HARDWARE_CONTROL_3     = 7'h1D;
  localparam logic [6:0] ADDR_SYS_STAT_LOW  = 7'h1E;
  localparam logic [6:0] ADDR_SYS_STAT_HIGH = 7'h1F;

  // Status register offsets, in status array order
  localparam logic [6:0] STAT_ADDR [STAT_COUNT] = '{
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h54, 7'h55};
  localparam logic [6:0] ADDR_WAKE_LEVEL    = 7'h48;
  localparam logic [6:0] ADDR_FAMILY_ID     = 7'h7E;

  // Implemented bits of each status register
  localparam logic [7:0] STAT_MASK [STAT_COUNT] = '{
    8'h63, 8'h9D, 8'h0F, 8'hCF, 8'h07, 8'h31, 8'h10, 8'h40, 8'h40};
  localparam logic [7:0] WAKE_LEVEL_MASK = 8'hD1;

  // Implemented (writable) bits of the control registers
  localparam logic [7:0] MASK_MODE_SUPPLY = 8'hDF;
  localparam logic [7:0] MASK_HARDWARE_CONTROL_0   = 8'h65;
  localparam logic [7:0] MASK_WATCHDOG    = 8'hF7;
  localparam logic [7:0] MASK_BUS_CTRL_0  = 8'h03;
  localparam logic [7:0] MASK_INT_WAKE    = 8'h44;
  localparam logic [7:0] MASK_EXT_WAKE    = 8'hA1;
  localparam logic [7:0] MASK_WAKE_PULL   = 8'hC3;
  localparam logic [7:0] MASK_BUS_CTRL_3  = 8'h10;
  localparam logic [7:0] MASK_TIMER       = 8'h7F;
  localparam logic [7:0] MASK_HARDWARE_CONTROL_1   = 8'hB8;
  localparam logic [7:0] MASK_HARDWARE_CONTROL_2   = 8'hFD;
  localparam logic [7:0] MASK_GPIO        = 8'h07;
  localparam logic [7:0] MASK_FULL        = 8'hFF;
  localparam logic [7:0] MASK_PWM_FREQ    = 8'h03;
  localparam logic [7:0] MASK_HARDWARE_CONTROL_3   = 8'h07;
  localparam logic [7:0] MASK_NONE        = 8'h00;

  // Hardware-modifiable bits
  localparam logic [7:0] RWH_MODE_SUPPLY  = 8'hDC;
  localparam logic [7:0] RWH_HARDWARE_CONTROL_0    = 8'h20;

  // Reset and restart values; restart keep masks mark unchanged bits
  localparam logic [7:0] POR_VALUE        = 8'h00;
  localparam logic [7:0] RESTART_VALUE    = 8'h00;
  localparam logic [7:0] KEEP_MODE_SUPPLY = 8'h03;
  localparam logic [7:0] KEEP_HARDWARE_CONTROL_0   = 8'h45;

  // Field positions
  localparam int         MODE_HI          = 7;
  localparam int         MODE_LO          = 6;
  localparam logic [1:0] MODE_SOFT_RESET  = 2'h3;
  localparam logic [7:0] BIT_PUMP_EN      = 8'h04;   // Charge pump enable in HW control 0
  localparam logic [7:0] BIT_SOFT_RST_CFG = 8'h40;   // Soft reset pin config in HW control 0
  localparam logic [7:0] BIT_LOCK0        = 8'h08;   // Level-0 lock in HW control 1
  localparam logic [7:0] BIT_LOCK1        = 8'h01;   // Level-1 lock in HW control 2

  // One serial frame, bit 0 first on the wire
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } spi_frame_t;

  // Whole control space as seen by the device functions
  typedef logic [CTRL_DEPTH-1:0][DATA_W-1:0] ctrl_image_t;

  // One event byte per clearable status register
  typedef logic [STAT_COUNT-1:0][DATA_W-1:0] stat_events_t;

endpackage : sbc_spi_pkg

// ==== verif/sbc_spi_properties.sv ====
// Checker for the serial register bank, watching its top-level ports only.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module sbc_spi_properties
  import sbc_spi_pkg::*;
(
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     nrst,
  // Link and device inputs
  input wire logic                     csn,
  input wire logic                     restartMode,
  // Outputs under watch
  input wire logic                     misoOeN,
  input wire sbc_spi_pkg::ctrl_image_t ctrlImage,
  input wire sbc_spi_pkg::spi_frame_t  lastFrame,
  input wire logic                     frameDone,
  input wire logic                     softResetPulse
);
  // Pump enable is frozen by either lock level
  logic pumpLock;
  assign pumpLock = ctrlImage[14][3] | ctrlImage[15][0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // A committed frame reports done within two cycles
  sequence s_done; ##[0:2] frameDone; endsequence
  property p_quiet; restartMode |-> misoOeN; endproperty
  a_quiet: assert property (p_quiet) else $error("miso driven in restart");
  property p_idle; csn [*4] |-> misoOeN; endproperty
  a_idle: assert property (p_idle) else $error("miso driven while idle");
  property p_pulse; frameDone |=> !frameDone; endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_done_cs; frameDone |-> csn; endproperty
  a_done_cs: assert property (p_done_cs) else $error("commit with select low");
  property p_soft;
    softResetPulse |-> frameDone && lastFrame.write && lastFrame.addr == ADDR_MODE_SUPPLY
      && lastFrame.data[7:6] == MODE_SOFT_RESET;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset without command");
  property p_rsvd;
    (ctrlImage[1] & ~MASK_MODE_SUPPLY) == 8'h00 && (ctrlImage[2] & ~MASK_HARDWARE_CONTROL_0) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_unmap; ctrlImage[0] == 8'h00 && ctrlImage[5] == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped register set");
  property p_lock1; $past(ctrlImage[15][0]) |-> ctrlImage[15][0]; endproperty
  a_lock1: assert property (p_lock1) else $error("level-1 lock released");
  property p_pump; $past(pumpLock) |-> $stable(ctrlImage[2][2]); endproperty
  a_pump: assert property (p_pump) else $error("locked pump bit changed");
  property p_lock0;
    $fell(ctrlImage[14][3]) |-> s_done ##0 (lastFrame.addr == ADDR_HARDWARE_CONTROL_1);
  endproperty
  a_lock0: assert property (p_lock0) else $error("level-0 lock lost");
  property p_duty; !$stable(ctrlImage[24]) |-> s_done; endproperty
  a_duty: assert property (p_duty) else $error("duty changed without frame");
endmodule : sbc_spi_properties

bind sbc_spi_register_bank sbc_spi_properties i_props (.clk(clk), .nrst(nrst), .csn(csn),
  .restartMode(restartMode), .misoOeN(misoOeN), .ctrlImage(ctrlImage),
  .lastFrame(lastFrame), .frameDone(frameDone), .softResetPulse(softResetPulse));

// ==== verif/spi_host.sv ====
// Host side of the serial link: a master sending one frame per call.
// Assumes the bank samples mosi on falling sclk and shifts miso on rising.
`timescale 1ns/1ps
module spi_host (
  // Bench clock
  input  wire logic clk,
  // Serial link pins
  input  wire logic miso,
  output logic      sclk,
  output logic      csn,
  output logic      mosi
);
  // Link idles with the clock still and no device selected
  initial begin
    sclk = 1'b0;
    csn  = 1'b1;
    mosi = 1'b0;
  end
  // Sends n bits of f, bit 0 first, and collects the response
  task automatic xfer(input logic [15:0] f, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk);
    csn <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      mosi <= f[i];
      repeat (4) @(posedge clk);
      // Bit i stands from its rising edge until the falling edge
      r[i] = miso;
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    csn  <= 1'b1;
    mosi <= ~mosi;
    repeat (12) @(posedge clk);
  endtask : xfer
endmodule : spi_host

// ==== verif/tb_top.sv ====
// Self-checking bench for the serial register bank, with an integer model.
// Assumes the package, the bank, the checker and the host model are compiled first.
`timescale 1ns/1ps
module tb_top;
  import sbc_spi_pkg::*;
  localparam logic [7:0] FID = 8'h3C;  // Arbitrary identity value
  // Writable bits of each control offset
  localparam logic [7:0] CM [32] = '{8'h00, 8'hDF, 8'h65, 8'hF7, 8'h03, 8'h00, 8'h44, 8'hA1,
    8'hC3, 8'h00, 8'h00, 8'h10, 8'h7F, 8'h00, 8'hB8, 8'hFD, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h07, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h07, 8'hFF, 8'hFF};
  // Lock exercise: address in the high byte, data in the low byte
  localparam logic [15:0] LK [13] = '{16'h0245, 16'h0E08, 16'h0200, 16'h1700, 16'h01C0,
    16'h0E00, 16'h0200, 16'h0F01, 16'h0245, 16'h0F00, 16'h01C0, 16'h011B, 16'h18A5};
  logic         clk = 1'b0, nrst = 1'b0, restartMode = 1'b0, restartEntry = 1'b0;
  logic         hwWrite = 1'b0, sclk, csn, mosi, miso;
  logic [4:0]   hwAddr = 5'h00;
  logic [7:0]   hwData = 8'h00, wakeLevel = 8'h00, lfsr = 8'h58;
  stat_events_t statusSet = '0;
  ctrl_image_t  ctrlImage;
  int           fails = 0, compares = 0, mdl [32], st [9];
  int           hw [$] = '{1, 2, 24};
  // Bench clock
  always #12.5 clk = ~clk;
  sbc_spi_register_bank #(.FAMILY_ID(FID)) i_dut (.clk(clk), .nrst(nrst), .sclk(sclk),
    .csn(csn), .mosi(mosi), .miso(miso), .misoOeN(), .restartMode(restartMode),
    .restartEntry(restartEntry), .hwWrite(hwWrite), .hwAddr(hwAddr), .hwData(hwData),
    .statusSet(statusSet), .wakeLevel(wakeLevel), .ctrlImage(ctrlImage), .lastFrame(),
    .frameDone(), .softResetPulse());
  spi_host i_host (.clk(clk), .miso(miso), .sclk(sclk), .csn(csn), .mosi(mosi));
  // Pseudo-random byte source
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Bits of an offset frozen by the current locks
  function automatic int lk(int a);
    int l1 = mdl[15] & 1;
    int l = l1 | ((mdl[14] >> 3) & 1);
    return a == 2 ? (l * 4 + l1 * 64) : a == 23 ? l * 7 : a == 15 ? l1 : 0;
  endfunction : lk
  // Model response byte of an offset
  function automatic int rd(int a);
    rd = a < 32 ? mdl[a] : a == 'h48 ? (wakeLevel & 8'hD1) : a == 'h7E ? FID : 0;
    for (int i = 0; i < 9; i++) if (STAT_ADDR[i] == a) rd = st[i];
  endfunction : rd
  // Model summary byte: one flag per status group
  function automatic int sif();
    return {st[8] != 0, st[7] != 0, st[0] != 0, (st[5] | st[6]) != 0,
            st[4] != 0, st[3] != 0, st[2] != 0, st[1] != 0};
  endfunction : sif
  // Model effect of a committed write
  task automatic commit(int a, int d);
    for (int i = 0; i < 9; i++) if (STAT_ADDR[i] == a) st[i] = 0;
    if (a == 1 && d[7:6] == 2'b11) begin
      for (int r = 0; r < 32; r++) mdl[r] &= lk(r) | (r == 14 ? 8 : r == 15 ? 1 : 0);
    end else if (a < 32) begin
      mdl[a] = (d & CM[a] & ~lk(a)) | (mdl[a] & lk(a));
    end
  endtask : commit
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d, input int n);
    logic [15:0] r;
    int          e, s;
    e = rd(a);
    s = sif();
    i_host.xfer({d, w, a}, n, r);
    if (n == 16 && !restartMode) begin
      check(r[15:8], e[7:0]);
      check(r[7:0], s[7:0]);
      if (w) commit(a, d);
    end
    foreach (mdl[k]) check(ctrlImage[k], mdl[k][7:0]);
  endtask : frame
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (mdl[k]) mdl[k] = 0;
    foreach (st[k]) st[k] = 0;
    repeat (4) @(posedge clk);
    foreach (mdl[k]) check(ctrlImage[k], 8'h00);
  endtask : do_reset
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    do_reset();
    for (int a = 0; a < 32; a++) begin
      lfsr = nxt(lfsr);
      frame(a[6:0], 1'b1, lfsr, 16);
      frame(a[6:0], 1'b0, ~lfsr, 16);
    end
    frame(7'h18, 1'b1, 8'h5A, 15);
    $display("test walk done");
    foreach (hw[k]) begin
      lfsr = nxt(lfsr);
      hwWrite <= 1'b1;
      hwAddr <= hw[k][4:0];
      hwData <= lfsr;
      @(posedge clk);
      hwWrite <= 1'b0;
      @(posedge clk);
      mdl[hw[k]] ^= (mdl[hw[k]] ^ lfsr) & (k == 0 ? RWH_MODE_SUPPLY : k == 1 ? RWH_HARDWARE_CONTROL_0 : 0);
    end
    frame(7'h18, 1'b0, 8'h00, 16);
    $display("test hardware done");
    do_reset();
    foreach (LK[k]) frame(LK[k][14:8], 1'b1, LK[k][7:0], 16);
    $display("test lock done");
    foreach (st[i]) begin
      lfsr = nxt(lfsr);
      statusSet[i] <= lfsr;
      @(posedge clk);
      statusSet[i] <= 8'h00;
      st[i] |= lfsr & STAT_MASK[i];
      frame(STAT_ADDR[i], 1'b1, 8'h00, 16);
      frame(STAT_ADDR[i], 1'b0, 8'h00, 16);
    end
    wakeLevel <= nxt(lfsr);
    @(posedge clk);
    frame(7'h48, 1'b1, 8'h00, 16);
    frame(7'h48, 1'b0, 8'h00, 16);
    frame(7'h7E, 1'b1, 8'h00, 16);
    frame(7'h49, 1'b1, 8'hFF, 16);
    $display("test status done");
    restartMode <= 1'b1;
    frame(7'h18, 1'b1, 8'h33, 16);
    restartEntry <= 1'b1;
    @(posedge clk);
    restartEntry <= 1'b0;
    restartMode <= 1'b0;
    mdl[1] &= KEEP_MODE_SUPPLY;
    mdl[2] &= KEEP_HARDWARE_CONTROL_0;
    frame(7'h01, 1'b0, 8'h00, 16);
    $display("test restart done");
    test_done();
  end
endmodule : tb_top
